// ### hw/abpu_pkg.sv
// Overview of operation
// - chan_b_pattern0_low holds channel B first pattern bits 15:0, resets to zero
// - chan_b_pattern_mid bits 15:8 hold channel B second pattern bits 7:0
// - chan_b_pattern_mid bits 7:0 hold channel B first pattern bits 23:16
// - appended_user_field bits 13:8 are appended to every channel B result while the test pattern is off
// - appended_user_field bits 5:0 are appended to every channel A result
// - gain_cal_and_init_key bits 13 and 6 are global gain calibration enables
// - key 11b at 33h bits 5:4 grants init access; 00b returns to normal
// - writing bit 14 of 90h from zero to one triggers a temperature load
// - channel B mode 3 alternates patterns, 0 and 1 first, 2 ramp
package abpu_pkg;
  localparam int unsigned ABPU_ADDR_W   = 8;
  localparam int unsigned ABPU_DATA_W   = 16;
  localparam int unsigned ABPU_CONV_W   = 18;
  localparam int unsigned ABPU_USER_W   = 6;
  localparam int unsigned ABPU_PAT_W    = 24;
  localparam int unsigned ABPU_INC_W    = 4;

  // register offsets
  localparam logic [7:0] ABPU_OFS_PAT0_LO = 8'h19;
  localparam logic [7:0] ABPU_OFS_PAT_MID = 8'h1a;
  localparam logic [7:0] ABPU_OFS_USER    = 8'h1c;
  localparam logic [7:0] ABPU_OFS_GAIN    = 8'h33;
  localparam logic [7:0] ABPU_OFS_TEMP    = 8'h90;

  localparam logic [15:0] ABPU_REG_RST    = 16'h0000;
  localparam logic [23:0] ABPU_PAT_RST    = 24'h00_0000;

  // field positions
  localparam int unsigned ABPU_MID_P1_LSB = 8;
  localparam int unsigned ABPU_MID_P0_MSB = 7;
  localparam int unsigned ABPU_MID_P0_LSB = 0;
  localparam int unsigned ABPU_USR_B_LSB  = 8;
  localparam int unsigned ABPU_USR_B_MSB  = 13;
  localparam int unsigned ABPU_USR_A_LSB  = 0;
  localparam int unsigned ABPU_USR_A_MSB  = 5;
  localparam int unsigned ABPU_GAIN_HI    = 13;
  localparam int unsigned ABPU_GAIN_LO    = 6;
  localparam int unsigned ABPU_KEY_LSB    = 4;
  localparam int unsigned ABPU_KEY_MSB    = 5;
  localparam int unsigned ABPU_TLOAD_BIT  = 14;

  localparam logic [1:0] ABPU_KEY_OPEN    = 2'h3;
  localparam logic [1:0] ABPU_KEY_NORMAL  = 2'h0;

  // channel B pattern select codes
  localparam logic [1:0] ABPU_MODE_FIX0   = 2'h0;
  localparam logic [1:0] ABPU_MODE_FIX1   = 2'h1;
  localparam logic [1:0] ABPU_MODE_RAMP   = 2'h2;
  localparam logic [1:0] ABPU_MODE_ALT    = 2'h3;
endpackage : abpu_pkg

// ### hw/abpu_pattern_gen.sv
`timescale 1ns/1ps
module abpu_pattern_gen
  import abpu_pkg::*;
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_sample,
  input  wire logic [1:0]            i_mode,
  input  wire logic [ABPU_INC_W-1:0] i_ramp_inc,
  input  wire logic [ABPU_PAT_W-1:0] i_first,
  input  wire logic [ABPU_PAT_W-1:0] i_second,
  output      logic [ABPU_PAT_W-1:0] o_pattern
);
  logic                  phase_q;
  logic                  phase_d;
  logic [ABPU_PAT_W-1:0] ramp_q;
  logic [ABPU_PAT_W-1:0] ramp_d;
  logic [ABPU_PAT_W-1:0] step;
  logic                  is_alt;
  logic                  is_ramp;

  // pattern selection by mode
  assign is_alt    = (i_mode == ABPU_MODE_ALT);
  assign is_ramp   = (i_mode == ABPU_MODE_RAMP);
  assign step      = ABPU_PAT_W'(i_ramp_inc) + ABPU_PAT_W'(1);
  assign o_pattern = is_ramp ? ramp_q :
                     (is_alt && phase_q) ? i_second : i_first;
  assign phase_d   = is_alt ? ~phase_q : 1'b0;
  assign ramp_d    = is_ramp ? ramp_q + step : ABPU_PAT_RST;

  // advance alternation phase and ramp once per sample
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      phase_q <= 1'b0;
      ramp_q  <= ABPU_PAT_RST;
    end else if (i_sample) begin
      phase_q <= phase_d;
      ramp_q  <= ramp_d;
    end
  end

  a_fixed_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_mode == ABPU_MODE_FIX0 || i_mode == ABPU_MODE_FIX1)
      |-> o_pattern == i_first)
    else $error("fixed mode does not give first pattern");

  a_alt_toggle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_sample && is_alt) |=> phase_q != $past(phase_q))
    else $error("alternate mode did not swap pattern");

  a_ramp_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_sample && is_ramp) |=>
      ramp_q == $past(ramp_q) + ABPU_PAT_W'($past(i_ramp_inc)) +
                ABPU_PAT_W'(1))
    else $error("ramp did not step by increment plus one");
endmodule : abpu_pattern_gen

// ### hw/abpu_regs.sv
`timescale 1ns/1ps
module abpu_regs
  import abpu_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [ABPU_ADDR_W-1:0] i_addr,
  input  wire logic [ABPU_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic                   i_conv_valid,
  input  wire logic [ABPU_CONV_W-1:0] i_conv_a,
  input  wire logic [ABPU_CONV_W-1:0] i_conv_b,
  input  wire logic                   i_chan_b_pattern_on,
  input  wire logic [1:0]             i_chan_b_pattern_select,
  input  wire logic [ABPU_INC_W-1:0]  i_chan_b_ramp_inc,
  input  wire logic [ABPU_DATA_W-1:0] i_chan_b_second_pattern_hi,
  output      logic [ABPU_DATA_W-1:0] o_rdata,
  output      logic [ABPU_PAT_W-1:0]  o_word_a,
  output      logic [ABPU_PAT_W-1:0]  o_word_b,
  output      logic                   o_word_valid,
  output      logic [ABPU_PAT_W-1:0]  o_chan_b_first_pattern,
  output      logic [ABPU_USER_W-1:0] o_user_bits_a,
  output      logic [ABPU_USER_W-1:0] o_user_bits_b,
  output      logic                   o_gain_cal_global_hi,
  output      logic                   o_gain_cal_global_lo,
  output      logic                   o_init_access,
  output      logic                   o_temp_load
);
  logic [ABPU_DATA_W-1:0] pat0_lo_q;
  logic [ABPU_DATA_W-1:0] pat_mid_q;
  logic [ABPU_DATA_W-1:0] user_q;
  logic [ABPU_DATA_W-1:0] gain_q;
  logic [ABPU_DATA_W-1:0] temp_q;
  logic [ABPU_DATA_W-1:0] rdata_q;
  logic [ABPU_DATA_W-1:0] rdata_d;
  logic [ABPU_DATA_W-1:0] rd_mux;
  logic                   init_q;
  logic                   init_d;
  logic                   tload_q;
  logic                   tload_d;
  logic [ABPU_PAT_W-1:0]  word_a_q;
  logic [ABPU_PAT_W-1:0]  word_b_q;
  logic [ABPU_PAT_W-1:0]  word_b_d;
  logic                   wvalid_q;
  logic [ABPU_PAT_W-1:0]  first_pat;
  logic [ABPU_PAT_W-1:0]  second_pat;
  logic [ABPU_PAT_W-1:0]  pattern_b;
  logic [ABPU_USER_W-1:0] usr_a;
  logic [ABPU_USER_W-1:0] usr_b;
  logic [1:0]             key_wr;
  logic                   sel_pat0;
  logic                   sel_mid;
  logic                   sel_user;
  logic                   sel_gain;
  logic                   sel_temp;
  logic                   wr_pat0;
  logic                   wr_mid;
  logic                   wr_user;
  logic                   wr_gain;
  logic                   wr_temp;

  // address decode and write strobes
  assign sel_pat0 = (i_addr == ABPU_OFS_PAT0_LO);
  assign sel_mid  = (i_addr == ABPU_OFS_PAT_MID);
  assign sel_user = (i_addr == ABPU_OFS_USER);
  assign sel_gain = (i_addr == ABPU_OFS_GAIN);
  assign sel_temp = (i_addr == ABPU_OFS_TEMP);
  assign wr_pat0  = i_wr & sel_pat0;
  assign wr_mid   = i_wr & sel_mid;
  assign wr_user  = i_wr & sel_user;
  assign wr_gain  = i_wr & sel_gain;
  assign wr_temp  = i_wr & sel_temp;

  // read mux, unmapped offsets read zero, no read side effects
  assign rd_mux = sel_pat0 ? pat0_lo_q :
                  sel_mid  ? pat_mid_q :
                  sel_user ? user_q    :
                  sel_gain ? gain_q    :
                  sel_temp ? temp_q    : ABPU_REG_RST;
  assign rdata_d = i_rd ? rd_mux : ABPU_REG_RST;

  // pattern assembly across the two pattern registers
  assign first_pat  = {pat_mid_q[ABPU_MID_P0_MSB:ABPU_MID_P0_LSB],
                       pat0_lo_q};
  assign second_pat = {i_chan_b_second_pattern_hi,
                       pat_mid_q[ABPU_DATA_W-1:ABPU_MID_P1_LSB]};

  // appended user fields
  assign usr_a = user_q[ABPU_USR_A_MSB:ABPU_USR_A_LSB];
  assign usr_b = user_q[ABPU_USR_B_MSB:ABPU_USR_B_LSB];

  // init key decode: 11b opens, 00b closes, other codes keep state
  assign key_wr = i_wdata[ABPU_KEY_MSB:ABPU_KEY_LSB];
  assign init_d = !wr_gain ? init_q :
                  (key_wr == ABPU_KEY_OPEN)   ? 1'b1 :
                  (key_wr == ABPU_KEY_NORMAL) ? 1'b0 : init_q;

  // load trigger only on a zero-to-one write of the trigger bit
  assign tload_d = wr_temp & i_wdata[ABPU_TLOAD_BIT] &
                   ~temp_q[ABPU_TLOAD_BIT];

  // channel B output: test pattern or result with user bits
  assign word_b_d = i_chan_b_pattern_on ? pattern_b :
                    {i_conv_b, usr_b};

  abpu_pattern_gen u_pattern_gen (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_sample   (i_conv_valid),
    .i_mode     (i_chan_b_pattern_select),
    .i_ramp_inc (i_chan_b_ramp_inc),
    .i_first    (first_pat),
    .i_second   (second_pat),
    .o_pattern  (pattern_b)
  );

  // register storage, reserved bits kept as written
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pat0_lo_q <= ABPU_REG_RST;
      pat_mid_q <= ABPU_REG_RST;
      user_q    <= ABPU_REG_RST;
      gain_q    <= ABPU_REG_RST;
      temp_q    <= ABPU_REG_RST;
    end else begin
      if (wr_pat0) pat0_lo_q <= i_wdata;
      if (wr_mid)  pat_mid_q <= i_wdata;
      if (wr_user) user_q    <= i_wdata;
      if (wr_gain) gain_q    <= i_wdata;
      if (wr_temp) temp_q    <= i_wdata;
    end
  end

  // read data, init access flag and load pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_q <= ABPU_REG_RST;
      init_q  <= 1'b0;
      tload_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      init_q  <= init_d;
      tload_q <= tload_d;
    end
  end

  // output words captured on each conversion
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      word_a_q <= ABPU_PAT_RST;
      word_b_q <= ABPU_PAT_RST;
      wvalid_q <= 1'b0;
    end else begin
      wvalid_q <= i_conv_valid;
      if (i_conv_valid) begin
        word_a_q <= {i_conv_a, usr_a};
        word_b_q <= word_b_d;
      end
    end
  end

  assign o_rdata                = rdata_q;
  assign o_word_a               = word_a_q;
  assign o_word_b               = word_b_q;
  assign o_word_valid           = wvalid_q;
  assign o_chan_b_first_pattern = first_pat;
  assign o_user_bits_a          = usr_a;
  assign o_user_bits_b          = usr_b;
  assign o_gain_cal_global_hi   = gain_q[ABPU_GAIN_HI];
  assign o_gain_cal_global_lo   = gain_q[ABPU_GAIN_LO];
  assign o_init_access          = init_q;
  assign o_temp_load            = tload_q;

  a_pat0_store: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_pat0 |=> o_chan_b_first_pattern[ABPU_DATA_W-1:0] ==
                $past(i_wdata))
    else $error("first pattern low word not stored");

  a_mid_split: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_mid |=> (o_chan_b_first_pattern[ABPU_PAT_W-1:ABPU_DATA_W] ==
                $past(i_wdata[ABPU_MID_P0_MSB:ABPU_MID_P0_LSB])) &&
               (second_pat[ABPU_MID_P0_MSB:0] ==
                $past(i_wdata[ABPU_DATA_W-1:ABPU_MID_P1_LSB])))
    else $error("middle register split wrong");

  a_user_b_tail: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_conv_valid && !i_chan_b_pattern_on) |=>
      o_word_valid && o_word_b == {$past(i_conv_b), $past(usr_b)})
    else $error("channel B user bits not appended");

  a_user_a_tail: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_conv_valid |=> o_word_a == {$past(i_conv_a), $past(usr_a)})
    else $error("channel A user bits not appended");

  a_gain_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_gain |=> o_gain_cal_global_hi == $past(i_wdata[ABPU_GAIN_HI]) &&
                o_gain_cal_global_lo == $past(i_wdata[ABPU_GAIN_LO]))
    else $error("gain calibration enables not stored");

  a_init_key: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_gain && key_wr == ABPU_KEY_OPEN) |=>
      o_init_access [*2] or (o_init_access ##1 wr_gain))
    else $error("init key did not grant access");

  a_init_close: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(wr_gain && key_wr == ABPU_KEY_OPEN) && !o_init_access
      |=> !o_init_access)
    else $error("init access rose without key");

  a_temp_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_temp_load |-> $past(wr_temp) && $past(i_wdata[ABPU_TLOAD_BIT]) &&
                    !$past(temp_q[ABPU_TLOAD_BIT]))
    else $error("load pulse without zero to one write");

  a_temp_rise: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_temp && i_wdata[ABPU_TLOAD_BIT] && !temp_q[ABPU_TLOAD_BIT])
      |=> o_temp_load ##1 !o_temp_load)
    else $error("trigger write gave no single pulse");

  a_read_data: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rd |=> o_rdata == $past(rd_mux))
    else $error("read data wrong");

  a_read_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == ABPU_REG_RST)
    else $error("read data not zero outside read answer");
endmodule : abpu_regs

// ### verification/abpu_regs_bench.sv
`timescale 1ns/1ps
module abpu_regs_bench;
  import abpu_pkg::*;
  logic             i_sys_clk, i_rst_n, i_wr, i_rd, i_conv_valid;
  logic [7:0]       i_addr;
  logic [15:0]      i_wdata, i_chan_b_second_pattern_hi, o_rdata;
  logic [17:0]      i_conv_a, i_conv_b;
  logic             i_chan_b_pattern_on;
  logic [1:0]       i_chan_b_pattern_select;
  logic [3:0]       i_chan_b_ramp_inc;
  logic [23:0]      o_word_a, o_word_b, o_chan_b_first_pattern;
  logic [5:0]       o_user_bits_a, o_user_bits_b;
  logic             o_word_valid, o_gain_cal_global_hi, o_gain_cal_global_lo;
  logic             o_init_access, o_temp_load;
  logic [15:0]      m19, m1a, m1c, m33, m90;
  logic             m_init;
  int               n_fail, n_compared, cyc;
  logic [7:0]       ofs [5] = '{8'h19, 8'h1a, 8'h1c, 8'h33, 8'h90};
  // reserved fields stay zero when software writes
  logic [15:0]      msk [5] = '{16'hffff, 16'hffff, 16'h3f3f, 16'h2070,
                                16'h4000};

  abpu_regs dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_conv_valid(i_conv_valid), .i_conv_a(i_conv_a), .i_conv_b(i_conv_b),
    .i_chan_b_pattern_on(i_chan_b_pattern_on),
    .i_chan_b_pattern_select(i_chan_b_pattern_select),
    .i_chan_b_ramp_inc(i_chan_b_ramp_inc),
    .i_chan_b_second_pattern_hi(i_chan_b_second_pattern_hi),
    .o_rdata(o_rdata), .o_word_a(o_word_a), .o_word_b(o_word_b),
    .o_word_valid(o_word_valid),
    .o_chan_b_first_pattern(o_chan_b_first_pattern),
    .o_user_bits_a(o_user_bits_a), .o_user_bits_b(o_user_bits_b),
    .o_gain_cal_global_hi(o_gain_cal_global_hi),
    .o_gain_cal_global_lo(o_gain_cal_global_lo),
    .o_init_access(o_init_access), .o_temp_load(o_temp_load));

  // clock, 8 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  // cut a hang short
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end

  task summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // expected read data from the shadow copies
  function logic [15:0] ev(input logic [7:0] a);
    case (a)
      8'h19:   ev = m19;
      8'h1a:   ev = m1a;
      8'h1c:   ev = m1c;
      8'h33:   ev = m33;
      8'h90:   ev = m90;
      default: ev = 16'h0000;
    endcase
  endfunction : ev

  task chk_outs;
    chk(o_chan_b_first_pattern, {m1a[7:0], m19}, "pattern");
    chk(o_user_bits_b, m1c[13:8], "user b");
    chk(o_user_bits_a, m1c[5:0], "user a");
    chk(o_gain_cal_global_hi, m33[13], "gain hi");
    chk(o_gain_cal_global_lo, m33[6], "gain lo");
    chk(o_init_access, m_init, "init access");
  endtask : chk_outs

  task wr(input logic [7:0] a, input logic [15:0] d);
    logic tl;
    tl = (a == 8'h90) && d[14] && !m90[14];
    case (a)
      8'h19: m19 = d;
      8'h1a: m1a = d;
      8'h1c: m1c = d;
      8'h33: m33 = d;
      8'h90: m90 = d;
      default: ;
    endcase
    if (a == 8'h33 && d[5:4] == 2'b11) m_init = 1'b1;
    if (a == 8'h33 && d[5:4] == 2'b00) m_init = 1'b0;
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1 chk(o_temp_load, tl, "temp load");
    chk_outs();
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, ev(a), "read");
    chk(o_temp_load, 1'b0, "read side effect");
  endtask : rd

  task cv(input logic pat, input logic [23:0] pv);
    logic [17:0] ca, cb;
    ca = 18'($urandom());
    cb = 18'($urandom());
    @(posedge i_sys_clk);
    i_conv_valid <= 1'b1;
    i_conv_a <= ca;
    i_conv_b <= cb;
    @(posedge i_sys_clk);
    i_conv_valid <= 1'b0;
    #1 chk(o_word_valid, 1'b1, "word valid");
    chk(o_word_a, {ca, m1c[5:0]}, "word a");
    chk(o_word_b, pat ? pv : {cb, m1c[13:8]}, "word b");
  endtask : cv

  // main sequence
  initial begin
    {i_wr, i_rd, i_conv_valid, i_chan_b_pattern_on} = '0;
    {i_addr, i_wdata, i_conv_a, i_conv_b} = '0;
    {i_chan_b_pattern_select, i_chan_b_ramp_inc} = '0;
    i_chan_b_second_pattern_hi = '0;
    {m19, m1a, m1c, m33, m90, m_init} = '0;
    {n_fail, n_compared, cyc} = '0;
    i_rst_n = 1'b0;
    void'($urandom(32'hc964f09d));
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    #1 chk_outs();
    for (int i = 0; i < 5; i++) rd(ofs[i]);
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      int k;
      k = $urandom_range(4);
      wr(ofs[k], 16'($urandom()) & msk[k]);
      rd(ofs[$urandom_range(4)]);
    end
    wr(8'h33, 16'h0030);
    wr(8'h33, 16'h0010);
    wr(8'h33, 16'h0020);
    wr(8'h33, 16'h0000);
    wr(8'h90, 16'h0000);
    wr(8'h90, 16'h4000);
    wr(8'h90, 16'h4000);
    wr(8'h90, 16'h0000);
    wr(8'h18, 16'hffff);
    rd(8'h18);
    rd(8'h91);
    $display("test registers done");
    for (int i = 0; i < 3; i++) cv(1'b0, '0);
    @(posedge i_sys_clk);
    i_chan_b_second_pattern_hi <= 16'($urandom());
    i_chan_b_ramp_inc <= 4'($urandom());
    i_chan_b_pattern_on <= 1'b1;
    for (int md = 0; md < 4; md++) begin
      @(posedge i_sys_clk);
      i_chan_b_pattern_select <= 2'(md);
      @(posedge i_sys_clk);
      for (int s = 0; s < 5; s++) begin
        logic [23:0] pv;
        pv = {m1a[7:0], m19};
        if (md == 3 && s % 2 == 1)
          pv = {i_chan_b_second_pattern_hi, m1a[15:8]};
        if (md == 2) pv = 24'(s * (i_chan_b_ramp_inc + 1));
        cv(1'b1, pv);
      end
    end
    $display("test conversion done");
    // mid-run reset must clear every register, flag and pattern phase
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    {m19, m1a, m1c, m33, m90, m_init} = '0;
    #1 chk_outs();
    chk(o_temp_load, 1'b0, "load after reset");
    for (int i = 0; i < 5; i++) rd(ofs[i]);
    cv(1'b1, 24'h00_0000);
    $display("test mid reset done");
    summarize();
  end
endmodule : abpu_regs_bench
